// ==== dv/ctp_timer_pair_tb.sv ====
// Self-checking testbench of the cascadable timer pair
`timescale 1ns/10ps
module ctp_timer_pair_tb;
   import ctp_pkg::*;
   // ---------------------------------------------------------------
   // Signals and model state
   // ---------------------------------------------------------------
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   ctp_events_t ev;
   logic        first_underflow_flag;
   logic        second_underflow_flag;
   logic [1:0]  timer_running;
   logic [31:0] rd;
   logic [31:0] rv;
   logic [7:0]  rc;
   logic [31:0] seed;
   logic [7:0]  m_ctl [2];
   int          m_cnt [2];
   int          m_rld [2];
   int          m_run [2];
   int          m_flag [2];
   int          n_errors;
   int          compares;
   int          cycles;

   ctp_timer_pair dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .events(ev),
      .first_underflow_flag(first_underflow_flag),
      .second_underflow_flag(second_underflow_flag), .timer_running(timer_running));

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         $display("ERROR cycle_limit expected below %0d seen %0d", 40000, cycles);
         finish_test();
      end
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One single transfer; the address phase is held until hready is seen high
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask

   function automatic void mstart(int t);
      m_cnt[t] = m_rld[t];
      m_run[t] = 1;
   endfunction

   function automatic void mtick(int t);
      if (m_run[t] == 0) return;
      if (m_cnt[t] != 0) begin
         m_cnt[t]--;
         return;
      end
      if (m_ctl[t][5:4] == 2'h2) begin
         m_run[t] = 0;
         return;
      end
      m_flag[t] = 1;
      if (m_ctl[t][3]) m_cnt[t] = m_rld[t];
      else m_run[t] = 0;
      if (m_ctl[1-t][1:0] == 2'h3) mtick(1 - t);
   endfunction

   // Event pulse, then time for the cascade to land, then the model
   task automatic pulse(input int k);
      int sm;
      case (k)
         0: ev.tick_fast <= 1'b1;
         1: ev.tick_slow <= 1'b1;
         2: ev.timer0_underflow <= 1'b1;
         3: ev.tx_end <= 1'b1;
         4: ev.rx_first_bits <= 1'b1;
         default: ev.lfo_level <= 1'b1;
      endcase
      @(posedge hclk);
      ev <= '0;
      repeat (3) @(posedge hclk);
      for (int t = 0; t < 2; t++) begin
         sm = m_ctl[t][5:4];
         if (k < 3 && m_ctl[t][1:0] == k) mtick(t);
         if (k == 3 && sm == 1) mstart(t);
         if (k == 4 && m_ctl[t][7] && sm < 2) m_run[t] = 0;
         if (k == 5 && sm > 1) begin
            if (m_run[t] != 0) m_run[t] = 0;
            else mstart(t);
         end
      end
   endtask

   task automatic setrld(input int t, input logic [15:0] r);
      bus(1'b1, t ? IDX_SECOND_RLD_HI : IDX_FIRST_RLD_HI, {24'h0, r[15:8]});
      bus(1'b1, t ? IDX_SECOND_RLD_LO : IDX_FIRST_RLD_LO, {24'h0, r[7:0]});
      m_rld[t] = r;
   endtask

   task automatic setup(input int t, input logic [7:0] c, input logic [15:0] r);
      bus(1'b1, t ? IDX_SECOND_CTRL : IDX_FIRST_CTRL, {24'h0, c});
      m_ctl[t] = c & CTRL_WRITE_MASK;
      setrld(t, r);
   endtask

   task automatic cmd(input logic [3:0] c);
      bus(1'b1, IDX_COMMAND, {28'h0, c});
      for (int t = 0; t < 2; t++) begin
         if (c[2+t]) m_run[t] = 0;
         else if (c[t]) mstart(t);
      end
   endtask

   task automatic clrf();
      bus(1'b1, IDX_STATUS, 32'h3);
      m_flag = '{0, 0};
   endtask

   // Counts are read only while no reception is under way
   task automatic verify();
      for (int t = 0; t < 2; t++) begin
         bus(1'b0, t ? IDX_SECOND_CNT_HI : IDX_FIRST_CNT_HI, 32'h0);
         check("count_high", rd, 32'(m_cnt[t] >> 8));
         bus(1'b0, t ? IDX_SECOND_CNT_LO : IDX_FIRST_CNT_LO, 32'h0);
         check("count_low", rd, 32'(m_cnt[t] & 255));
      end
      bus(1'b0, IDX_STATUS, 32'h0);
      check("status", rd, 32'(m_run[1] * 32 + m_run[0] * 16 + m_flag[1] * 2 + m_flag[0]));
      check("running", {30'h0, timer_running}, 32'(m_run[1] * 2 + m_run[0]));
      check("flag_first", {31'h0, first_underflow_flag}, 32'(m_flag[0]));
      check("flag_second", {31'h0, second_underflow_flag}, 32'(m_flag[1]));
   endtask

   task automatic finish_test();
      $display("counts: compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      ev = '0;
      seed = 32'h4665a48c;
      n_errors = 0;
      compares = 0;
      cycles = 0;
      m_ctl = '{8'h0, 8'h0};
      m_cnt = '{0, 0};
      m_rld = '{0, 0};
      m_run = '{0, 0};
      m_flag = '{0, 0};
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 8'h14; i <= 8'h22; i++) begin
         bus(1'b0, 8'(i), 32'h0);
         check("reset_value", rd, 32'h0);
      end
      bus(1'b1, IDX_FIRST_CNT_HI, 32'hff);
      bus(1'b1, 8'h22, 32'hff);
      setup(0, 8'hff, 16'h0);
      setup(1, 8'h44, 16'h0);
      bus(1'b0, IDX_FIRST_CTRL, 32'h0);
      check("control_first", rd, 32'hbb);
      bus(1'b0, IDX_SECOND_CTRL, 32'h0);
      check("control_second", rd, 32'h00);
      bus(1'b0, 8'h22, 32'h0);
      check("unmapped", rd, 32'h0);
      verify();
      $display("test registers done");
      for (int cs = 0; cs < 3; cs++) begin
         setup(0, 8'(cs), 16'(xs()) | 16'h0100);
         setup(1, 8'((cs + 1) % 3), 16'(xs()) | 16'h0100);
         cmd(4'h3);
         for (int k = 0; k < 3; k++) pulse(k);
         pulse(cs);
         verify();
      end
      $display("test sources done");
      for (int a = 0; a < 2; a++) begin
         clrf();
         setup(0, 8'(a * 8), 16'h0002);
         setup(1, 8'(a * 8), 16'h0001);
         cmd(4'h3);
         repeat (2) pulse(0);
         verify();
         repeat (2) pulse(0);
         verify();
         cmd(4'h1);
         verify();
      end
      $display("test reload done");
      for (int t = 0; t < 2; t++) begin
         setup(t, 8'h08, 16'h0001);
         setup(1 - t, 8'h03, 16'h0002);
         cmd(4'h3);
         repeat (7) pulse(0);
         verify();
         cmd(4'hc);
      end
      $display("test cascade done");
      setup(0, 8'h00, 16'h1234);
      cmd(4'h1);
      pulse(0);
      setrld(0, 16'h0055);
      pulse(0);
      verify();
      cmd(4'h1);
      verify();
      $display("test reload_write done");
      for (int sm = 0; sm < 4; sm++) begin
         cmd(4'hc);
         setup(0, 8'(8'h80 | sm * 16), 16'h0003);
         setup(1, 8'(sm * 16 + 8), 16'h0002);
         pulse(3);
         pulse(0);
         verify();
         pulse(4);
         pulse(0);
         verify();
         pulse(5);
         repeat (4) pulse(0);
         verify();
         pulse(5);
         pulse(4);
         verify();
      end
      $display("test start_modes done");
      repeat (200) begin
         rv = xs();
         case (rv[2:0])
            3'h0: begin
               rc = rv[15:8];
               if (!rv[3] && rc[1:0] == 2'h3) rc[1] = 1'b0;
               setup(int'(rv[3]), rc, 16'(rv[18:16]));
            end
            3'h1: cmd(rv[11:8]);
            3'h2: clrf();
            default: pulse(int'(rv[10:8]) % 6);
         endcase
         if (rv[31:28] == 4'h0) verify();
      end
      verify();
      $display("test random done");
      finish_test();
   end
endmodule

// ==== logic/ctp_pkg.sv ====
// Constants, field layouts and carrier types of the cascadable timer pair
package ctp_pkg;

   // ---------------------------------------------------------------
   // Register indices; the byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_FIRST_CTRL     = 8'h14;
   localparam logic [7:0] IDX_FIRST_RLD_HI   = 8'h15;
   localparam logic [7:0] IDX_FIRST_RLD_LO   = 8'h16;
   localparam logic [7:0] IDX_FIRST_CNT_HI   = 8'h17;
   localparam logic [7:0] IDX_FIRST_CNT_LO   = 8'h18;
   localparam logic [7:0] IDX_SECOND_CTRL    = 8'h19;
   localparam logic [7:0] IDX_SECOND_RLD_HI  = 8'h1a;
   localparam logic [7:0] IDX_SECOND_RLD_LO  = 8'h1b;
   localparam logic [7:0] IDX_SECOND_CNT_HI  = 8'h1c;
   localparam logic [7:0] IDX_SECOND_CNT_LO  = 8'h1d;
   localparam logic [7:0] IDX_STATUS         = 8'h20;
   localparam logic [7:0] IDX_COMMAND        = 8'h21;

   // Address split of a word access
   localparam int         ADDR_IDX_LSB       = 2;
   localparam int         ADDR_IDX_MSB       = 9;

   // ---------------------------------------------------------------
   // Control register layout and reset values
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CTP_SM_NONE    = 2'h0,
      CTP_SM_TX_END  = 2'h1,
      CTP_SM_TRIM    = 2'h2,
      CTP_SM_TRIM_UF = 2'h3
   } ctp_start_mode_t;

   typedef enum logic [1:0] {
      CTP_CS_FAST    = 2'h0,
      CTP_CS_SLOW    = 2'h1,
      CTP_CS_TIMER0  = 2'h2,
      CTP_CS_SIBLING = 2'h3
   } ctp_clock_select_t;

   typedef struct packed {
      logic              stop_on_receive;
      logic              reserved_bit6;
      ctp_start_mode_t   start_mode;
      logic              auto_reload;
      logic              reserved_bit2;
      ctp_clock_select_t clock_select;
   } ctp_ctrl_t;

   localparam logic [7:0]  CTRL_WRITE_MASK   = 8'hbb;
   localparam ctp_ctrl_t   CTRL_RESET        = ctp_ctrl_t'(8'h00);
   localparam logic [15:0] RELOAD_RESET      = 16'h0000;
   localparam logic [15:0] COUNT_RESET       = 16'h0000;
   localparam logic [15:0] COUNT_ZERO        = 16'h0000;
   localparam logic [15:0] COUNT_STEP        = 16'h0001;

   // Status and command bit positions (per timer: base plus timer number)
   localparam int          ST_FLAG_LSB       = 0;
   localparam int          ST_RUN_LSB        = 4;
   localparam int          CMD_START_LSB     = 0;
   localparam int          CMD_STOP_LSB      = 2;

   // ---------------------------------------------------------------
   // Bus encodings
   // ---------------------------------------------------------------
   localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
   localparam logic        HRESP_OKAY        = 1'h0;
   localparam logic [31:0] HRDATA_RESET      = 32'h0000_0000;

   // Frontend events, all one-cycle pulses except the trimmed level
   typedef struct packed {
      logic tick_fast;
      logic tick_slow;
      logic timer0_underflow;
      logic tx_end;
      logic rx_first_bits;
      logic lfo_level;
   } ctp_events_t;

endpackage

// ==== logic/ctp_timer_pair.sv ====
// Two cascadable 16-bit down counters with an AHB-Lite register slave
`timescale 1ns/10ps
module ctp_timer_pair (
   // Clock and reset
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic [31:0]               hrdata,
   output logic                      hresp,
   // Frontend events
   input  wire ctp_pkg::ctp_events_t events,
   // Timer state
   output logic                      first_underflow_flag,
   output logic                      second_underflow_flag,
   output logic [1:0]                timer_running
);
   import ctp_pkg::*;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   ctp_ctrl_t   ctrl_r   [2];
   logic [15:0] reload_r [2];
   logic [15:0] count_r  [2];
   logic [1:0]  run_r;
   logic [1:0]  uf_r;
   logic [1:0]  flag_r;
   logic [1:0]  cmd_start_r;
   logic [1:0]  cmd_stop_r;
   logic        lfo_prev_r;
   logic        pend_r;
   logic        wr_r;
   logic        mapped_r;
   logic [7:0]  idx_r;
   logic        hreadyout_r;
   logic [31:0] hrdata_r;

   logic        wr_now;
   logic        lfo_edge;
   logic [7:0]  rd_byte;
   logic [7:0]  wbyte;
   logic [1:0]  tick;
   logic [1:0]  start_evt;
   logic [1:0]  stop_evt;
   logic [1:0]  zero_tick;
   logic [1:0]  uf_evt;

   function automatic logic tick_sel(input ctp_clock_select_t sel,
                                     input ctp_events_t ev,
                                     input logic sibling_uf);
      logic t;
      t = 1'b0;
      case (sel)
         CTP_CS_FAST:   t = ev.tick_fast;
         CTP_CS_SLOW:   t = ev.tick_slow;
         CTP_CS_TIMER0: t = ev.timer0_underflow;
         default:       t = sibling_uf;
      endcase
      return t;
   endfunction

   function automatic logic wr_hit(input logic en, input logic [7:0] idx,
                                   input logic [7:0] target);
      return en && (idx == target);
   endfunction

   assign hreadyout             = hreadyout_r;
   assign hrdata                = hrdata_r;
   assign hresp                 = HRESP_OKAY;
   assign first_underflow_flag  = flag_r[0];
   assign second_underflow_flag = flag_r[1];
   assign timer_running         = run_r;

   // ---------------------------------------------------------------
   // Bus slave: one wait state on every NONSEQ access
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_r      <= 1'b0;
         wr_r        <= 1'b0;
         mapped_r    <= 1'b0;
         idx_r       <= 8'h00;
         hreadyout_r <= 1'b1;
         hrdata_r    <= HRDATA_RESET;
      end else if (pend_r) begin
         pend_r      <= 1'b0;
         hreadyout_r <= 1'b1;
         if (!wr_r) begin
            hrdata_r <= {24'h000000, rd_byte};
         end
      end else if (hready && hsel && htrans == HTRANS_NONSEQ) begin
         pend_r      <= 1'b1;
         wr_r        <= hwrite;
         idx_r       <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
         mapped_r    <= (haddr[31:ADDR_IDX_MSB+1] == '0) && (haddr[1:0] == 2'h0);
         hreadyout_r <= 1'b0;
      end
   end

   assign wr_now = pend_r && wr_r && mapped_r;
   assign wbyte  = hwdata[7:0];

   // Read decode; unmapped indices read as zero
   always_comb begin
      rd_byte = 8'h00;
      if (!mapped_r) begin
         rd_byte = 8'h00;
      end else if (idx_r == IDX_FIRST_CTRL) begin
         rd_byte = ctrl_r[0];
      end else if (idx_r == IDX_FIRST_RLD_HI) begin
         rd_byte = reload_r[0][15:8];
      end else if (idx_r == IDX_FIRST_RLD_LO) begin
         rd_byte = reload_r[0][7:0];
      end else if (idx_r == IDX_FIRST_CNT_HI) begin
         rd_byte = count_r[0][15:8];
      end else if (idx_r == IDX_FIRST_CNT_LO) begin
         rd_byte = count_r[0][7:0];
      end else if (idx_r == IDX_SECOND_CTRL) begin
         rd_byte = ctrl_r[1];
      end else if (idx_r == IDX_SECOND_RLD_HI) begin
         rd_byte = reload_r[1][15:8];
      end else if (idx_r == IDX_SECOND_RLD_LO) begin
         rd_byte = reload_r[1][7:0];
      end else if (idx_r == IDX_SECOND_CNT_HI) begin
         rd_byte = count_r[1][15:8];
      end else if (idx_r == IDX_SECOND_CNT_LO) begin
         rd_byte = count_r[1][7:0];
      end else if (idx_r == IDX_STATUS) begin
         rd_byte[ST_FLAG_LSB +: 2] = flag_r;
         rd_byte[ST_RUN_LSB +: 2]  = run_r;
      end
   end

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r[0]   <= CTRL_RESET;
         ctrl_r[1]   <= CTRL_RESET;
         reload_r[0] <= RELOAD_RESET;
         reload_r[1] <= RELOAD_RESET;
      end else begin
         // Reserved bits are never stored
         if (wr_hit(wr_now, idx_r, IDX_FIRST_CTRL)) begin
            ctrl_r[0] <= ctp_ctrl_t'(wbyte & CTRL_WRITE_MASK);
         end
         if (wr_hit(wr_now, idx_r, IDX_SECOND_CTRL)) begin
            ctrl_r[1] <= ctp_ctrl_t'(wbyte & CTRL_WRITE_MASK);
         end
         if (wr_hit(wr_now, idx_r, IDX_FIRST_RLD_HI)) begin
            reload_r[0][15:8] <= wbyte;
         end
         if (wr_hit(wr_now, idx_r, IDX_FIRST_RLD_LO)) begin
            reload_r[0][7:0] <= wbyte;
         end
         if (wr_hit(wr_now, idx_r, IDX_SECOND_RLD_HI)) begin
            reload_r[1][15:8] <= wbyte;
         end
         if (wr_hit(wr_now, idx_r, IDX_SECOND_RLD_LO)) begin
            reload_r[1][7:0] <= wbyte;
         end
      end
   end

   // Command pulses and trimmed-signal edge history
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_start_r <= 2'h0;
         cmd_stop_r  <= 2'h0;
         lfo_prev_r  <= 1'b0;
      end else begin
         lfo_prev_r <= events.lfo_level;
         if (wr_hit(wr_now, idx_r, IDX_COMMAND)) begin
            cmd_start_r <= wbyte[CMD_START_LSB +: 2];
            cmd_stop_r  <= wbyte[CMD_STOP_LSB +: 2];
         end else begin
            cmd_start_r <= 2'h0;
            cmd_stop_r  <= 2'h0;
         end
      end
   end

   assign lfo_edge = events.lfo_level && !lfo_prev_r;

   // ---------------------------------------------------------------
   // Timers; each one's sibling is the other of the pair
   // ---------------------------------------------------------------
   for (genvar i = 0; i < 2; i++) begin : g_tmr
      localparam int SIB = 1 - i;
      logic trim;

      assign trim         = ctrl_r[i].start_mode[1];
      assign tick[i]      = tick_sel(ctrl_r[i].clock_select, events,
                                     uf_r[SIB]);
      assign start_evt[i] = cmd_start_r[i]
                          || (ctrl_r[i].start_mode == CTP_SM_TX_END
                              && events.tx_end)
                          || (trim && lfo_edge && !run_r[i]);
      assign stop_evt[i]  = (trim && lfo_edge && run_r[i])
                          || (!trim && ctrl_r[i].stop_on_receive
                              && events.rx_first_bits);
      assign zero_tick[i] = run_r[i] && tick[i] && count_r[i] == COUNT_ZERO
                          && !cmd_stop_r[i] && !start_evt[i] && !stop_evt[i];
      // Trimming without underflow just ends at zero
      assign uf_evt[i]    = zero_tick[i]
                          && ctrl_r[i].start_mode != CTP_SM_TRIM;

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            run_r[i]   <= 1'b0;
            count_r[i] <= COUNT_RESET;
         end else if (cmd_stop_r[i]) begin
            run_r[i] <= 1'b0;
         end else if (start_evt[i]) begin
            run_r[i]   <= 1'b1;
            count_r[i] <= reload_r[i];
         end else if (stop_evt[i]) begin
            run_r[i] <= 1'b0;
         end else if (zero_tick[i]) begin
            if (ctrl_r[i].auto_reload && uf_evt[i]) begin
               count_r[i] <= reload_r[i];
            end else begin
               run_r[i] <= 1'b0;
            end
         end else if (run_r[i] && tick[i]) begin
            count_r[i] <= count_r[i] - COUNT_STEP;
         end
      end

      // Underflow pulse for the sibling and sticky flag; set beats clear
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            uf_r[i]   <= 1'b0;
            flag_r[i] <= 1'b0;
         end else begin
            uf_r[i] <= uf_evt[i];
            if (uf_evt[i]) begin
               flag_r[i] <= 1'b1;
            end else if (wr_hit(wr_now, idx_r, IDX_STATUS)
                         && wbyte[ST_FLAG_LSB + i]) begin
               flag_r[i] <= 1'b0;
            end
         end
      end

      // -------------------------------------------------------------
      // Checks
      // -------------------------------------------------------------
      property p_stop_rx;
         @(posedge hclk) disable iff (!hresetn)
         run_r[i] && !trim && ctrl_r[i].stop_on_receive && events.rx_first_bits
         && !start_evt[i] |=> !run_r[i] ##1 (!run_r[i] || $past(start_evt[i]));
      endproperty
      a_stop_rx: assert property (p_stop_rx) else $error("rx stop missed");

      property p_trim_ignores_rx;
         @(posedge hclk) disable iff (!hresetn)
         run_r[i] && trim && ctrl_r[i].stop_on_receive && events.rx_first_bits
         && !lfo_edge && !cmd_stop_r[i] && !zero_tick[i] |=> run_r[i];
      endproperty
      a_trim_ignores_rx: assert property (p_trim_ignores_rx)
         else $error("rx stopped a trimming timer");

      property p_tx_start;
         @(posedge hclk) disable iff (!hresetn)
         ctrl_r[i].start_mode == CTP_SM_TX_END && events.tx_end && !cmd_stop_r[i]
         |=> run_r[i] && count_r[i] == $past(reload_r[i]);
      endproperty
      a_tx_start: assert property (p_tx_start) else $error("no start at tx end");

      property p_auto_reload;
         @(posedge hclk) disable iff (!hresetn)
         uf_evt[i] && ctrl_r[i].auto_reload
         |=> run_r[i] && count_r[i] == $past(reload_r[i]) && uf_r[i];
      endproperty
      a_auto_reload: assert property (p_auto_reload) else $error("no reload");

      property p_hold_zero;
         @(posedge hclk) disable iff (!hresetn)
         zero_tick[i] && !ctrl_r[i].auto_reload
         |=> !run_r[i] && count_r[i] == COUNT_ZERO;
      endproperty
      a_hold_zero: assert property (p_hold_zero) else $error("did not stop at zero");

      property p_flag;
         @(posedge hclk) disable iff (!hresetn)
         uf_evt[i] |=> flag_r[i] && uf_r[i] ##1 (!uf_r[i] || $past(uf_evt[i]));
      endproperty
      a_flag: assert property (p_flag) else $error("underflow flag not set");

      // Only a status write with the bit set may drop a raised flag
      property p_flag_sticky;
         @(posedge hclk) disable iff (!hresetn)
         flag_r[i] && !(wr_hit(wr_now, idx_r, IDX_STATUS) && wbyte[ST_FLAG_LSB + i])
         |=> flag_r[i];
      endproperty
      a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

      property p_trim_no_underflow;
         @(posedge hclk) disable iff (!hresetn)
         zero_tick[i] && ctrl_r[i].start_mode == CTP_SM_TRIM
         |=> !run_r[i] && !uf_r[i] && count_r[i] == COUNT_ZERO;
      endproperty
      a_trim_no_underflow: assert property (p_trim_no_underflow)
         else $error("underflow in plain trimming");

      property p_decrement;
         @(posedge hclk) disable iff (!hresetn)
         run_r[i] && tick[i] && count_r[i] != COUNT_ZERO && !start_evt[i]
         && !stop_evt[i] && !cmd_stop_r[i]
         |=> count_r[i] == $past(count_r[i]) - COUNT_STEP;
      endproperty
      a_decrement: assert property (p_decrement) else $error("bad decrement");

      property p_reload_write_quiet;
         @(posedge hclk) disable iff (!hresetn)
         !start_evt[i] && !(run_r[i] && tick[i]) |=> count_r[i] == $past(count_r[i]);
      endproperty
      a_reload_write_quiet: assert property (p_reload_write_quiet)
         else $error("count changed without tick or start");

      // A sibling underflow must move a nonzero count by exactly one
      property p_cascade;
         @(posedge hclk) disable iff (!hresetn)
         ctrl_r[i].clock_select == CTP_CS_SIBLING && uf_r[SIB] && run_r[i]
         && count_r[i] != COUNT_ZERO && !start_evt[i] && !stop_evt[i] && !cmd_stop_r[i]
         |=> count_r[i] == $past(count_r[i]) - COUNT_STEP;
      endproperty
      a_cascade: assert property (p_cascade) else $error("cascade tick lost");

      c_reload_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
         uf_evt[i] && ctrl_r[i].auto_reload);
      c_cascade: cover property (@(posedge hclk) disable iff (!hresetn)
         ctrl_r[i].clock_select == CTP_CS_SIBLING && uf_r[SIB] && run_r[i]);
      c_trim: cover property (@(posedge hclk) disable iff (!hresetn)
         trim && lfo_edge && run_r[i]);
      c_trim_rx: cover property (@(posedge hclk) disable iff (!hresetn)
         trim && ctrl_r[i].stop_on_receive && events.rx_first_bits && run_r[i]);
   end

   property p_bus_wait;
      @(posedge hclk) disable iff (!hresetn)
      hready && hsel && htrans == HTRANS_NONSEQ && !pend_r
      |=> !hreadyout ##1 hreadyout;
   endproperty
   a_bus_wait: assert property (p_bus_wait) else $error("bad bus timing");

   c_status_read: cover property (@(posedge hclk) disable iff (!hresetn)
      pend_r && !wr_r && idx_r == IDX_STATUS);

endmodule
